// ===== common/led_pkg.sv
// Constants, types and register layout shared by the LED blink and fade channel.
`default_nettype none
package led_pkg;
  // Register indices of the channel bank.
  localparam logic [2:0] IDX_ON_TIME = 3'h0;
  localparam logic [2:0] IDX_ON_INT = 3'h1;
  localparam logic [2:0] IDX_OFF_SET = 3'h2;
  localparam logic [2:0] IDX_FADE_IN = 3'h3;
  localparam logic [2:0] IDX_FADE_OUT = 3'h4;
  localparam logic [2:0] IDX_LEVEL = 3'h5;
  // Reset values.
  localparam logic [7:0] RST_ON_TIME = 8'h00;
  localparam logic [7:0] RST_ON_INT = 8'hFF;
  localparam logic [7:0] RST_OFF_SET = 8'h00;
  localparam logic [7:0] RST_FADE_IN = 8'h00;
  localparam logic [7:0] RST_FADE_OUT = 8'h00;
  // Field layout: time fields 4:0, off time 7:3, off intensity 2:0.
  localparam logic [7:0] TIME_FIELD_MASK = 8'h1F;
  localparam int OFF_TIME_LSB = 3;
  localparam int OFF_INT_W = 3;
  // Timing: each unit is one PWM period of 255 led_drive_clock periods.
  localparam logic [7:0] PWM_LAST = 8'hFE;
  localparam logic [4:0] TIME_SPLIT = 5'h10;
  localparam logic [13:0] MULT_SHORT = 14'h0040;
  localparam logic [13:0] MULT_LONG = 14'h0200;
  localparam logic [8:0] FADE_LONG = 9'h010;
  // Divider.
  localparam int DIV_SEL_W = 3;
  localparam int DIV_CNT_W = 6;

  typedef enum logic [1:0] {PH_ON, PH_FALL, PH_OFF, PH_RISE} led_phase_t;

  typedef struct packed {
    logic we;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_wr_t;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic tick;
  } div_state_t;

  typedef struct packed {
    led_phase_t phase;
    logic [7:0] on_time;
    logic [7:0] on_int;
    logic [7:0] off_set;
    logic [7:0] fade_in;
    logic [7:0] fade_out;
    logic [7:0] pwm_cnt;
    logic [13:0] dur_cnt;
    logic [8:0] step_cnt;
    logic [7:0] level;
    logic sink;
    logic [7:0] rdata;
  } chan_state_t;
endpackage
`default_nettype wire

// ===== design/led_clk_div.sv
// Divider that turns the oscillator into led_drive_clock enable ticks.
`default_nettype none
module led_clk_div
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Divider select, zero stops the ticks.
  input wire logic [led_pkg::DIV_SEL_W-1:0] sel_i,
  // One-cycle tick per led_drive_clock period.
  output logic tick_o
);
  led_pkg::div_state_t s_r;
  led_pkg::div_state_t s_nxt;
  logic [led_pkg::DIV_CNT_W:0] span;

  always_comb
  begin
    span = 7'((7'h01 << (sel_i - 3'h1)) - 7'h01);
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (sel_i == 3'h0)
    begin
      s_nxt.cnt = '0;
    end
    else if ({1'b0, s_r.cnt} >= span)
    begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 6'h01;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      s_r <= '0;
    else if (clk_en_i)
      s_r <= s_nxt;
  end

  assign tick_o = s_r.tick;
endmodule // led_clk_div
`default_nettype wire

// ===== design/led_blink_fade_channel.sv
// One LED driver channel: blink timing, intensity PWM and fade ramps.
//
// Overview of operation
// - On-time field zero: static mode, on phase follows pin data bit.
// - On-time 1..15: on phase lasts 64 x value x 255 clock periods.
// - On-time 16..31: on phase lasts 512 x value x 255 clock periods.
// - Linear mode: on level equals on-intensity register, reset 0xFF.
// - Log mode on fade-capable channel: on level is nonlinear map of register.
// - Off-time field zero: single shot, off phase follows pin data bit.
// - Off-time 1..15 uses 64, 16..31 uses 512, times value times 255.
// - Linear mode: off level is four times off-intensity field.
// - Log mode: off level is same map applied to four times field.
// - Fade-in zero disables; 1..15 lasts span x value x 255 periods.
// - Fade-in 16..31 lasts sixteen x span x value x 255 periods.
// - Fade-out zero disables; 1..15 lasts span x value x 255 periods.
// - Fade-out 16..31 lasts sixteen x span x value x 255 periods.
// - Clock field divides oscillator by 2^(field-1); zero disables driver.
// - Driver runs only while the channel enable bit is one.
// - Mode bit selects linear (0) or logarithmic (1) mapping.
`default_nettype none
module led_blink_fade_channel
#(
  parameter bit FADE_CAPABLE = 1'b1
)
(
  // Clock, reset and enable.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Register access.
  input wire led_pkg::reg_wr_t reg_wr_i,
  input wire logic [2:0] reg_rd_addr_i,
  output logic [7:0] reg_rdata_o,
  // Shared configuration bits.
  input wire logic [led_pkg::DIV_SEL_W-1:0] clk_div_sel_i,
  input wire logic log_mode_i,
  input wire logic driver_en_i,
  input wire logic pin_data_i,
  // Open-drain pin: enable high sinks LED current.
  output logic pin_sink_oe_o
);
  led_pkg::chan_state_t s_r;
  led_pkg::chan_state_t s_nxt;
  logic tick;
  logic active;
  logic [7:0] on_level;
  logic [7:0] off_level;
  logic [7:0] cur_level;
  logic [4:0] on_f;
  logic [4:0] off_f;
  logic [4:0] rise_f;
  logic [4:0] fall_f;
  logic unit;

  ////////////////////////////////////////////////////////////////////////////
  // Intensity mapping and durations.

  // Square law keeps both ends fixed: 0 maps to 0 and 255 to 255.
  function automatic logic [7:0] log_map(input logic [7:0] x);
    logic [15:0] p;
    p = (16'(x) * 16'(x)) + 16'(x);
    return p[15:8];
  endfunction

  function automatic logic [13:0] phase_units(input logic [4:0] f);
    return (f < led_pkg::TIME_SPLIT) ? 14'(f) * led_pkg::MULT_SHORT : 14'(f) * led_pkg::MULT_LONG;
  endfunction

  // Units per one-step level change, so a ramp lasts span x this.
  function automatic logic [8:0] step_units(input logic [4:0] f);
    return (f < led_pkg::TIME_SPLIT) ? 9'(f) : 9'(f) * led_pkg::FADE_LONG;
  endfunction

  led_clk_div u_div
  (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .sel_i(clk_div_sel_i),
    .tick_o(tick)
  );

  assign on_f = s_r.on_time[4:0];
  assign off_f = s_r.off_set[7:led_pkg::OFF_TIME_LSB];
  assign rise_f = s_r.fade_in[4:0];
  assign fall_f = s_r.fade_out[4:0];
  assign active = driver_en_i && (clk_div_sel_i != 3'h0);
  assign unit = tick && (s_r.pwm_cnt == led_pkg::PWM_LAST);

  always_comb
  begin
    on_level = (FADE_CAPABLE && log_mode_i) ? log_map(s_r.on_int) : s_r.on_int;
    off_level = {3'b000, s_r.off_set[led_pkg::OFF_INT_W-1:0], 2'b00};
    if (FADE_CAPABLE && log_mode_i)
      off_level = log_map(off_level);
    case (s_r.phase)
      led_pkg::PH_ON: cur_level = on_level;
      led_pkg::PH_OFF: cur_level = off_level;
      default: cur_level = s_r.level;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    s_nxt = s_r;
    case (reg_rd_addr_i)
      led_pkg::IDX_ON_TIME: s_nxt.rdata = s_r.on_time;
      led_pkg::IDX_ON_INT: s_nxt.rdata = s_r.on_int;
      led_pkg::IDX_OFF_SET: s_nxt.rdata = s_r.off_set;
      led_pkg::IDX_FADE_IN: s_nxt.rdata = s_r.fade_in;
      led_pkg::IDX_FADE_OUT: s_nxt.rdata = s_r.fade_out;
      led_pkg::IDX_LEVEL: s_nxt.rdata = cur_level;
      default: s_nxt.rdata = 8'h00;
    endcase
    if (reg_wr_i.we)
    begin
      case (reg_wr_i.addr)
        led_pkg::IDX_ON_TIME: s_nxt.on_time = reg_wr_i.wdata & led_pkg::TIME_FIELD_MASK;
        led_pkg::IDX_ON_INT: s_nxt.on_int = reg_wr_i.wdata;
        led_pkg::IDX_OFF_SET: s_nxt.off_set = reg_wr_i.wdata;
        led_pkg::IDX_FADE_IN: s_nxt.fade_in = reg_wr_i.wdata & led_pkg::TIME_FIELD_MASK;
        led_pkg::IDX_FADE_OUT: s_nxt.fade_out = reg_wr_i.wdata & led_pkg::TIME_FIELD_MASK;
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end
    if (!active)
    begin
      // Driver off: the pin simply follows the data bit, low means LED on.
      s_nxt.phase = led_pkg::PH_ON;
      s_nxt.pwm_cnt = 8'h00;
      s_nxt.dur_cnt = 14'h0000;
      s_nxt.step_cnt = 9'h000;
      s_nxt.sink = !pin_data_i;
    end
    else if (tick)
    begin
      s_nxt.pwm_cnt = unit ? 8'h00 : s_r.pwm_cnt + 8'h01;
      s_nxt.sink = s_r.pwm_cnt < cur_level;
      if (unit)
      begin
        case (s_r.phase)
          led_pkg::PH_ON:
          begin
            // A static phase holds its count at zero, so a later timed setting starts a full count.
            s_nxt.dur_cnt = (on_f == 5'h00) ? 14'h0000 : s_r.dur_cnt + 14'h0001;
            // Static mode waits for the data bit; a timed phase waits for its count.
            if ((on_f == 5'h00) ? pin_data_i : (s_nxt.dur_cnt >= phase_units(on_f)))
            begin
              s_nxt.dur_cnt = 14'h0000;
              s_nxt.step_cnt = 9'h000;
              s_nxt.level = on_level;
              s_nxt.phase = (fall_f == 5'h00) ? led_pkg::PH_OFF : led_pkg::PH_FALL;
            end
          end
          led_pkg::PH_FALL:
          begin
            s_nxt.step_cnt = s_r.step_cnt + 9'h001;
            if (s_r.level <= off_level)
              s_nxt.phase = led_pkg::PH_OFF;
            else if (s_nxt.step_cnt >= step_units(fall_f))
            begin
              s_nxt.step_cnt = 9'h000;
              s_nxt.level = s_r.level - 8'h01;
              if (s_nxt.level <= off_level)
                s_nxt.phase = led_pkg::PH_OFF;
            end
          end
          led_pkg::PH_OFF:
          begin
            s_nxt.dur_cnt = (off_f == 5'h00) ? 14'h0000 : s_r.dur_cnt + 14'h0001;
            if ((off_f == 5'h00) ? !pin_data_i : (s_nxt.dur_cnt >= phase_units(off_f)))
            begin
              s_nxt.dur_cnt = 14'h0000;
              s_nxt.step_cnt = 9'h000;
              s_nxt.level = off_level;
              s_nxt.phase = (rise_f == 5'h00) ? led_pkg::PH_ON : led_pkg::PH_RISE;
            end
          end
          led_pkg::PH_RISE:
          begin
            s_nxt.step_cnt = s_r.step_cnt + 9'h001;
            if (s_r.level >= on_level)
              s_nxt.phase = led_pkg::PH_ON;
            else if (s_nxt.step_cnt >= step_units(rise_f))
            begin
              s_nxt.step_cnt = 9'h000;
              s_nxt.level = s_r.level + 8'h01;
              if (s_nxt.level >= on_level)
                s_nxt.phase = led_pkg::PH_ON;
            end
          end
          default: s_nxt.phase = led_pkg::PH_ON;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_r <= '0;
      s_r.phase <= led_pkg::PH_ON;
      s_r.on_time <= led_pkg::RST_ON_TIME;
      s_r.on_int <= led_pkg::RST_ON_INT;
      s_r.off_set <= led_pkg::RST_OFF_SET;
      s_r.fade_in <= led_pkg::RST_FADE_IN;
      s_r.fade_out <= led_pkg::RST_FADE_OUT;
    end
    else if (clk_en_i)
      s_r <= s_nxt;
  end

  assign reg_rdata_o = s_r.rdata;
  assign pin_sink_oe_o = s_r.sink;
endmodule // led_blink_fade_channel
`default_nettype wire

// ===== tb/led_load.sv
// Model of the LED and its series resistor on the open-drain pin.
`default_nettype none
module led_load
(
  // Pin enable from the channel.
  input wire logic sink_i,
  // Light seen by the bench.
  output logic lit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // No pull-up on the pin, so a released pin leaves the LED dark.
  assign lit_o = sink_i;
endmodule // led_load
`default_nettype wire

// ===== tb/led_chan_asserts.sv
// Port checker for the LED blink and fade channel.
`default_nettype none
module led_chan_asserts
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Registers.
  input wire led_pkg::reg_wr_t reg_wr_i,
  input wire logic [2:0] reg_rd_addr_i,
  input wire logic [7:0] reg_rdata_o,
  // Configuration and pin.
  input wire logic [led_pkg::DIV_SEL_W-1:0] clk_div_sel_i,
  input wire logic log_mode_i,
  input wire logic driver_en_i,
  input wire logic pin_data_i,
  input wire logic pin_sink_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rst_out: assert property ($fell(sys_rst_i) |-> !pin_sink_oe_o && reg_rdata_o == 8'h00)
    else $error("outputs not cleared by reset");
  chk_idle_follow: assert property (clk_en_i && (!driver_en_i || clk_div_sel_i == 3'h0)
    |=> pin_sink_oe_o == !$past(pin_data_i)) else $error("idle pin does not follow data");
  chk_freeze_hold: assert property (!clk_en_i |=> $stable(pin_sink_oe_o) && $stable(reg_rdata_o))
    else $error("outputs moved while frozen");
  chk_rd_unmapped: assert property (clk_en_i && reg_rd_addr_i[2:1] == 2'h3 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_time_mask: assert property (clk_en_i && reg_wr_i.we && reg_wr_i.addr inside {3'h0, 3'h3, 3'h4}
    ##1 clk_en_i && reg_rd_addr_i == $past(reg_wr_i.addr)
    |=> reg_rdata_o == ($past(reg_wr_i.wdata, 2) & led_pkg::TIME_FIELD_MASK)) else $error("time field bad");
  chk_full_write: assert property (clk_en_i && reg_wr_i.we && reg_wr_i.addr inside {3'h1, 3'h2}
    ##1 clk_en_i && reg_rd_addr_i == $past(reg_wr_i.addr)
    |=> reg_rdata_o == $past(reg_wr_i.wdata, 2)) else $error("level field bad");
  chk_rd_stable: assert property (clk_en_i && !reg_wr_i.we ##1 clk_en_i && $stable(reg_rd_addr_i)
    && reg_rd_addr_i != led_pkg::IDX_LEVEL |=> $stable(reg_rdata_o)) else $error("read data moved");
  // Pin updates only on ticks, so with a tick every second cycle it cannot change twice in a row.
  chk_tick_space: assert property (clk_en_i && driver_en_i && clk_div_sel_i == 3'h2 && $changed(pin_sink_oe_o)
    && $past(clk_div_sel_i) == 3'h2 && $past(driver_en_i) && $past(driver_en_i, 2)
    |=> $stable(pin_sink_oe_o)) else $error("pin changed between ticks");
endmodule // led_chan_asserts
bind led_blink_fade_channel led_chan_asserts u_chk (.core_clk_i, .sys_rst_i, .clk_en_i, .reg_wr_i,
  .reg_rd_addr_i, .reg_rdata_o, .clk_div_sel_i, .log_mode_i, .driver_en_i, .pin_data_i, .pin_sink_oe_o);
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the LED blink and fade channel.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  led_pkg::reg_wr_t reg_wr_i = '0;
  logic [2:0] reg_rd_addr_i = 3'h0;
  logic [7:0] reg_rdata_o;
  logic [2:0] clk_div_sel_i = 3'h0;
  logic log_mode_i = 1'b0;
  logic driver_en_i = 1'b0;
  logic pin_data_i = 1'b1;
  logic pin_sink_oe_o;
  logic lit;
  logic [2:0] a;
  logic [7:0] v;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int run;
  int mdl [8] = '{0, 8'hFF, 0, 0, 0, 0, 0, 0};
  int unsigned rng = 96389;
  led_blink_fade_channel dut (.core_clk_i, .sys_rst_i, .clk_en_i, .reg_wr_i, .reg_rd_addr_i, .reg_rdata_o,
    .clk_div_sel_i, .log_mode_i, .driver_en_i, .pin_data_i, .pin_sink_oe_o);
  led_load load (.sink_i(pin_sink_oe_o), .lit_o(lit));
  initial forever #4 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // The read index follows the write so read-back of a write lands two cycles later.
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_i = '{1'b1, ad, d};
    reg_rd_addr_i = ad;
    @(negedge core_clk_i);
    reg_wr_i.we = 1'b0;
    if (ad < 3'h5)
      mdl[ad] = (ad == 3'h1 || ad == 3'h2) ? int'(d) : int'(d & 8'h1F);
  endtask
  task automatic rd(input logic [2:0] ad, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_rd_addr_i = ad;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (lit === lvl && n < 20000)
    begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  // Samples the level register once per PWM period over a ramp and the period after it.
  task automatic ramp(input int from, input int to, input int v);
    int span;
    int e;
    span = (to > from) ? to - from : from - to;
    for (int k = 1; k <= span * v + 1; k++)
    begin
      @(posedge lit);
      repeat (100) @(negedge core_clk_i);
      if (k > span * v)
        e = to;
      else
        e = (to > from) ? from + (k - 1) / v : from - (k - 1) / v;
      chk(16'(reg_rdata_o), 16'(e));
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 48; i++)
    begin
      a = (i < 8) ? 3'(i) : 3'(rnd());
      if (i >= 8)
        wr(a, rnd());
      rd(a, v);
      if (a != 3'h5)
        chk(16'(v), 16'(mdl[a]));
    end
    for (int i = 0; i < 16; i++)
    begin
      @(negedge core_clk_i);
      v = rnd();
      pin_data_i = v[0];
      driver_en_i = i[3];
      @(negedge core_clk_i);
      chk(16'(pin_sink_oe_o), 16'(!pin_data_i));
    end
    clk_en_i = 1'b0;
    pin_data_i = ~pin_data_i;
    repeat (3) @(negedge core_clk_i);
    chk(16'(pin_sink_oe_o), 16'(pin_data_i));
    clk_en_i = 1'b1;
    driver_en_i = 1'b0;
    clk_div_sel_i = 3'h2;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h80);
    repeat (20) @(negedge core_clk_i);
    driver_en_i = 1'b1;
    repeat (1200) @(negedge core_clk_i);
    // A second reset mid-run must restore the register defaults.
    sys_rst_i = 1'b1;
    clk_div_sel_i = 3'h1;
    log_mode_i = 1'b1;
    pin_data_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    rd(3'h1, v);
    chk(16'(v), 16'h00FF);
    wr(3'h0, 8'h01);
    wr(3'h2, 8'h08);
    repeat (600) @(negedge core_clk_i);
    run_len(1'b1, run);
    run_len(1'b0, run);
    chk(16'(run), 16'(64 * 255));
    run_len(1'b1, run);
    chk(16'(run), 16'(64 * 255));
    // Static on and single-shot off let the data bit start each ramp without long timed phases.
    driver_en_i = 1'b0;
    log_mode_i = 1'b0;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h0C);
    wr(3'h2, 8'h01);
    wr(3'h3, 8'h02);
    wr(3'h4, 8'h01);
    @(negedge core_clk_i);
    reg_rd_addr_i = 3'h5;
    driver_en_i = 1'b1;
    @(posedge lit);
    @(negedge core_clk_i);
    pin_data_i = 1'b1;
    ramp(12, 4, 1);
    pin_data_i = 1'b0;
    ramp(4, 12, 2);
    log_mode_i = 1'b1;
    wr(3'h1, 8'hC0);
    rd(3'h5, v);
    chk(16'(v), 16'((192 * 192 + 192) / 256));
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
